/* File: hw/ltc_pkg.sv */
// Shared constants for the LCD timing and temperature compensation core.
// Assumes one 20 MHz clock and a simple strobed register port.
package ltc_pkg;
  // Clock and frame timing.
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned FRAME_DIV   = 48;
  localparam int unsigned FR_MIN_HZ   = 60;
  localparam int unsigned FR_STEP_HZ  = 10;
  localparam logic [4:0]  FR_CODE_MAX = 5'h18;
  localparam int unsigned STEP_MV     = 30;
  // Register offsets.
  localparam logic [3:0] ADR_CTRL  = 4'h0;
  localparam logic [3:0] ADR_SLOPE = 4'h1;
  localparam logic [3:0] ADR_VOLT  = 4'h2;
  localparam logic [3:0] ADR_TEMP  = 4'h3;
  localparam logic [3:0] ADR_PRESC = 4'h4;
  localparam logic [3:0] ADR_FINAL = 4'h5;
  localparam logic [3:0] ADR_DCOL  = 4'h6;
  localparam logic [3:0] ADR_DDATA = 4'h7;
  localparam logic [3:0] ADR_STAT  = 4'h8;
  // Control field positions.
  localparam int unsigned CTRL_COMP = 0;
  localparam int unsigned CTRL_EXT  = 1;
  localparam int unsigned CTRL_COE  = 2;
  localparam int unsigned CTRL_MODE = 4;
  // Reset values.
  localparam logic [7:0]  TEMP_RST  = 8'h40;
  localparam logic [7:0]  VOLT_RST  = 8'h00;
  localparam logic [11:0] SLOPE_RST = 12'h000;
  localparam logic [4:0]  PRESC_RST = 5'h00;
  localparam logic [5:0]  NUM_COLS  = 6'h3c;
  // Region bounds of the temperature code and reference points.
  localparam logic [7:0] TOP_A = 8'h20;
  localparam logic [7:0] TOP_B = 8'h40;
  localparam logic [7:0] TOP_C = 8'h60;
  localparam logic [7:0] TOP_D = 8'h7e;
  localparam logic signed [12:0] REF_A  = 13'sh0020;
  localparam logic signed [12:0] REF_B  = 13'sh0040;
  localparam logic signed [12:0] REF_D  = 13'sh0060;
  localparam logic signed [12:0] SPAN   = 13'sh0020;
  localparam logic signed [12:0] HOLD_N = 13'sh001f;
  localparam logic signed [12:0] ROUND  = 13'sh0004;
  localparam int unsigned FRAC_BITS = 3;

  typedef enum logic [2:0] {LTC_MUX_STATIC, LTC_MUX_2, LTC_MUX_4, LTC_MUX_6, LTC_MUX_8} ltc_mux_t;

  // Slope code to coefficient, in eighths.
  function automatic logic signed [4:0] ltc_coeff8(input logic [2:0] code);
    case (code)
      3'h0:    return 5'sh00;
      3'h1:    return -5'sh01;
      3'h2:    return -5'sh02;
      3'h3:    return -5'sh04;
      3'h4:    return -5'sh0a;
      3'h5:    return 5'sh01;
      3'h6:    return 5'sh02;
      default: return 5'sh04;
    endcase
  endfunction
endpackage

/* File: hw/ltc_comp_if.sv */
// Bundle between the register core and the compensation datapath.
// Assumes both ends run on the same clock.
interface ltc_comp_if;
  logic              comp_enable_flag;
  logic [11:0]       slope_codes;
  logic [7:0]        lcd_voltage_setting;
  logic [7:0]        temp_code;
  logic [7:0]        final_code;
  logic signed [7:0] temp_offset_term;
  modport calc (input comp_enable_flag, slope_codes, lcd_voltage_setting, temp_code,
                output final_code, temp_offset_term);
  modport core (output comp_enable_flag, slope_codes, lcd_voltage_setting, temp_code,
                input final_code, temp_offset_term);
endinterface

/* File: hw/ltc_temp_comp.sv */
// Piecewise-linear temperature offset and clamped final voltage code.
// Assumes inputs come from registers on the same clock; latency is two cycles from temperature or slopes, one from voltage or enable.
module ltc_temp_comp (
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  ltc_comp_if.calc  cif
);
  typedef struct packed {
    logic signed [12:0] off8;
    logic signed [7:0]  vt;
    logic [7:0]         fin;
  } ltc_tc_st_t;

  ltc_tc_st_t st_ff;
  ltc_tc_st_t nxt_st;
  logic signed [12:0] t, ma, mb, mc, md, rnd, sum;

  // Offset is kept in eighths so every coefficient is an exact integer.
  always_comb begin
    nxt_st = st_ff;
    t   = 13'($signed({5'h00, cif.temp_code}));
    ma  = 13'(ltc_pkg::ltc_coeff8(cif.slope_codes[2:0]));
    mb  = 13'(ltc_pkg::ltc_coeff8(cif.slope_codes[5:3]));
    mc  = 13'(ltc_pkg::ltc_coeff8(cif.slope_codes[8:6]));
    md  = 13'(ltc_pkg::ltc_coeff8(cif.slope_codes[11:9]));
    if (cif.temp_code <= ltc_pkg::TOP_A) begin // [RULE2] [RULE8]
      nxt_st.off8 = 13'((t - ltc_pkg::REF_A) * ma - ltc_pkg::SPAN * mb);
    end else if (cif.temp_code <= ltc_pkg::TOP_B) begin // [RULE8]
      nxt_st.off8 = 13'((t - ltc_pkg::REF_B) * mb);
    end else if (cif.temp_code <= ltc_pkg::TOP_C) begin // [RULE8]
      nxt_st.off8 = 13'((t - ltc_pkg::REF_B) * mc);
    end else if (cif.temp_code <= ltc_pkg::TOP_D) begin // [RULE8]
      nxt_st.off8 = 13'((t - ltc_pkg::REF_D) * md + ltc_pkg::SPAN * mc);
    end else begin
      nxt_st.off8 = 13'(ltc_pkg::HOLD_N * md + ltc_pkg::SPAN * mc); // [RULE9]
    end
    // Each unit of the rounded term is one 30 mV step.
    rnd = (st_ff.off8 + ltc_pkg::ROUND) >>> ltc_pkg::FRAC_BITS; // [RULE4]
    nxt_st.vt = rnd[7:0];
    sum = 13'($signed({5'h00, cif.lcd_voltage_setting})) + rnd; // [RULE6]
    if (!cif.comp_enable_flag) begin
      nxt_st.fin = cif.lcd_voltage_setting; // [RULE1]
    end else if (sum < 13'sh0000) begin
      nxt_st.fin = 8'h00; // [RULE7]
    end else if (sum > 13'sh00ff) begin
      nxt_st.fin = 8'hff; // [RULE7]
    end else begin
      nxt_st.fin = sum[7:0];
    end
  end

  // Reset state matches a 40h code, where the offset is zero.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_ff <= '0; // [RULE5]
    end else begin
      st_ff <= nxt_st; // [RULE20]
    end
  end

  assign cif.final_code       = st_ff.fin;
  assign cif.temp_offset_term = st_ff.vt;

  ref_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE5]
    (cif.temp_code == ltc_pkg::TEMP_RST) [*2] |=> cif.temp_offset_term == 8'sh00)
    else $error("offset not zero at reference code");
  region_b_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE8]
    (cif.temp_code == 8'h22 && cif.slope_codes[5:3] == 3'h3) [*2]
    |=> cif.temp_offset_term == 8'sh0f)
    else $error("region b offset wrong");
  hold_top_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE9]
    (cif.temp_code > 8'h7f && cif.slope_codes[11:6] == 6'h3f) [*2]
    |=> cif.temp_offset_term == 8'sh20)
    else $error("offset above range not held");
  clamp_high_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE7]
    (cif.comp_enable_flag && cif.lcd_voltage_setting == 8'hf0 && cif.temp_code == 8'h00
     && cif.slope_codes[5:0] == 6'h24) [*2] |=> cif.final_code == 8'hff)
    else $error("high clamp missing");
  clamp_low_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE7]
    (cif.comp_enable_flag && cif.lcd_voltage_setting == 8'h10 && cif.temp_code == 8'h00
     && cif.slope_codes[5:0] == 6'h3f) [*2] |=> cif.final_code == 8'h00)
    else $error("low clamp missing");
  comp_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE1]
    !cif.comp_enable_flag |=> cif.final_code == $past(cif.lcd_voltage_setting))
    else $error("offset applied while disabled");
endmodule // ltc_temp_comp

/* File: hw/ltc_core.sv */
// LCD driver digital core: registers, clock selection, frame timing,
// backplane mapping, segment data and temperature compensation.
// Assumes a 20 MHz clock, synchronous pin inputs and a strobed register port.
// What this block does
// [RULE1] Apply offset only when compensation enabled
// [RULE2] Four equal regions, eight slope choices each
// [RULE3] Slope codes map to fixed coefficients
// [RULE4] One offset unit equals one 30 mV step
// [RULE5] Reset: voltage zero, temperature code 40h
// [RULE6] Add signed offset to voltage setting
// [RULE7] Saturate sum to 8-bit range
// [RULE8] Offset computed piecewise per temperature region
// [RULE9] Hold top offset above compensated range
// [RULE10] One clock: internal or external source
// [RULE11] Clock pin driven only when enabled
// [RULE12] External select makes clock pin input
// [RULE13] Frame rate is active clock over 48
// [RULE14] Internal frame rate 60-300 Hz, 10 Hz steps
// [RULE15] Driven clock duty may differ from half
// [RULE16] External clock must keep running
// [RULE17] Backplanes repeat according to multiplex mode
// [RULE18] Sixty segments from display data and row
// [RULE19] Temperature code: 0.9375 per step, -40 offset
// [RULE20] Offset recomputed within a few cycles
//
// Implementation choices: the address map and the address-and-strobe port.
module ltc_core (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        clk_pin_i,
  output logic             clk_pin_o,
  output logic             clk_pin_oe_o,
  output logic             frame_tick_o,
  output logic      [7:0]  backplane_out_o,
  output logic      [59:0] segment_out_o,
  output logic      [7:0]  vlcd_code_o
);
  typedef struct packed {
    logic              comp_en;
    logic              ext_sel;
    logic              clock_pin_drive_enable;
    ltc_pkg::ltc_mux_t mode;
    logic [11:0]       slopes;
    logic [7:0]        vset;
    logic [7:0]        temp;
    logic [4:0]        presc;
    logic [5:0]        dcol;
    logic [59:0][7:0]  disp;
    logic [15:0]       rdata;
    logic [15:0]       div_cnt;
    logic              clk_out;
    logic              pin_prev;
    logic [5:0]        fcnt;
    logic [5:0]        sub_cnt;
    logic [2:0]        row;
    logic              frame;
    logic [7:0]        bp;
    logic [59:0]       seg;
  } ltc_core_st_t;

  ltc_core_st_t st_ff;
  ltc_core_st_t nxt_st;
  ltc_comp_if   cif ();
  logic [15:0]  div_tab [32];
  logic [15:0]  div_len;
  logic         tick;
  logic [5:0]   row_len;
  logic [2:0]   rows;

  // Clock divider per frame-rate code: the active clock is 48 times the frame rate.
  for (genvar g = 0; g < 32; g++) begin : g_div
    localparam int unsigned CODE = (g > 24) ? 24 : g;
    assign div_tab[g] = 16'(ltc_pkg::CLK_HZ /
      (ltc_pkg::FRAME_DIV * (ltc_pkg::FR_MIN_HZ + ltc_pkg::FR_STEP_HZ * CODE))); // [RULE14]
  end

  assign div_len = div_tab[st_ff.presc];

  // Rows per frame and ticks per row for each multiplex mode.
  always_comb begin
    case (st_ff.mode)
      ltc_pkg::LTC_MUX_STATIC: begin
        rows    = 3'h0;
        row_len = 6'h30;
      end
      ltc_pkg::LTC_MUX_2: begin
        rows    = 3'h1;
        row_len = 6'h18;
      end
      ltc_pkg::LTC_MUX_4: begin
        rows    = 3'h3;
        row_len = 6'h0c;
      end
      ltc_pkg::LTC_MUX_6: begin
        rows    = 3'h5;
        row_len = 6'h08;
      end
      default: begin
        rows    = 3'h7;
        row_len = 6'h06;
      end
    endcase
  end

  // The timing tick comes from one source only, so the rest of the core never
  // sees two clocks; a stopped external clock simply freezes the frame.
  always_comb begin
    if (st_ff.ext_sel) begin
      tick = clk_pin_i && !st_ff.pin_prev; // [RULE10] [RULE12] [RULE16]
    end else begin
      // A compare of greater-or-equal keeps a shorter prescaler from wrapping the count.
      tick = (st_ff.div_cnt >= div_len - 16'h0001); // [RULE10] [RULE14]
    end
  end

  // Next-state logic: register port, timing chain and drive outputs.
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.pin_prev = clk_pin_i;
    nxt_st.frame    = 1'b0;
    nxt_st.rdata    = 16'h0000;
    // Register writes.
    if (reg_wr_i) begin
      case (reg_addr_i)
        ltc_pkg::ADR_CTRL: begin
          nxt_st.comp_en = reg_wdata_i[ltc_pkg::CTRL_COMP];
          nxt_st.ext_sel = reg_wdata_i[ltc_pkg::CTRL_EXT];
          nxt_st.clock_pin_drive_enable     = reg_wdata_i[ltc_pkg::CTRL_COE];
          if (reg_wdata_i[ltc_pkg::CTRL_MODE +: 3] > 3'h4) begin
            nxt_st.mode = ltc_pkg::LTC_MUX_8;
          end else begin
            nxt_st.mode = ltc_pkg::ltc_mux_t'(reg_wdata_i[ltc_pkg::CTRL_MODE +: 3]);
          end
        end
        ltc_pkg::ADR_SLOPE: nxt_st.slopes = reg_wdata_i[11:0]; // [RULE2] [RULE3]
        ltc_pkg::ADR_VOLT:  nxt_st.vset = reg_wdata_i[7:0];
        ltc_pkg::ADR_TEMP:  nxt_st.temp = reg_wdata_i[7:0]; // [RULE19]
        ltc_pkg::ADR_PRESC: begin
          if (reg_wdata_i[4:0] > ltc_pkg::FR_CODE_MAX) begin
            nxt_st.presc = ltc_pkg::FR_CODE_MAX;
          end else begin
            nxt_st.presc = reg_wdata_i[4:0]; // [RULE14]
          end
        end
        ltc_pkg::ADR_DCOL:  nxt_st.dcol = reg_wdata_i[5:0];
        ltc_pkg::ADR_DDATA: begin
          if (st_ff.dcol < ltc_pkg::NUM_COLS) begin
            nxt_st.disp[st_ff.dcol] = reg_wdata_i[7:0];
          end
        end
        default: ;
      endcase
    end
    // Register reads; unmapped offsets answer zero.
    if (reg_rd_i) begin
      case (reg_addr_i)
        ltc_pkg::ADR_CTRL:  nxt_st.rdata = {9'h000, st_ff.mode, 1'b0, st_ff.clock_pin_drive_enable,
                                            st_ff.ext_sel, st_ff.comp_en};
        ltc_pkg::ADR_SLOPE: nxt_st.rdata = {4'h0, st_ff.slopes};
        ltc_pkg::ADR_VOLT:  nxt_st.rdata = {8'h00, st_ff.vset};
        ltc_pkg::ADR_TEMP:  nxt_st.rdata = {8'h00, st_ff.temp};
        ltc_pkg::ADR_PRESC: nxt_st.rdata = {11'h000, st_ff.presc};
        ltc_pkg::ADR_FINAL: nxt_st.rdata = {cif.temp_offset_term, cif.final_code};
        ltc_pkg::ADR_DCOL:  nxt_st.rdata = {10'h000, st_ff.dcol};
        ltc_pkg::ADR_DDATA: begin
          if (st_ff.dcol < ltc_pkg::NUM_COLS) begin
            nxt_st.rdata = {8'h00, st_ff.disp[st_ff.dcol]};
          end
        end
        ltc_pkg::ADR_STAT:  nxt_st.rdata = {7'h00, st_ff.fcnt, st_ff.row};
        default:            nxt_st.rdata = 16'h0000;
      endcase
    end
    // Internal divider; with an odd length the high phase is one cycle short.
    if (st_ff.ext_sel || tick) begin
      nxt_st.div_cnt = 16'h0000;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 16'h0001;
    end
    nxt_st.clk_out = (nxt_st.div_cnt < {1'b0, div_len[15:1]}); // [RULE15]
    // Frame counter of 48 ticks, split into rows of equal length.
    if (tick) begin
      if (st_ff.fcnt == 6'(ltc_pkg::FRAME_DIV - 1)) begin
        nxt_st.fcnt    = 6'h00; // [RULE13]
        nxt_st.sub_cnt = 6'h00;
        nxt_st.row     = 3'h0;
        nxt_st.frame   = 1'b1;
      end else begin
        nxt_st.fcnt = st_ff.fcnt + 6'h01;
        if (st_ff.sub_cnt >= row_len - 6'h01) begin
          nxt_st.sub_cnt = 6'h00;
          nxt_st.row     = (st_ff.row >= rows) ? 3'h0 : st_ff.row + 3'h1;
        end else begin
          nxt_st.sub_cnt = st_ff.sub_cnt + 6'h01;
        end
      end
    end
    // Backplane i follows row i modulo the number of rows in the mode.
    for (int i = 0; i < 8; i++) begin
      case (st_ff.mode)
        ltc_pkg::LTC_MUX_STATIC: nxt_st.bp[i] = 1'b1; // [RULE17]
        ltc_pkg::LTC_MUX_2:      nxt_st.bp[i] = (st_ff.row == 3'(i % 2)); // [RULE17]
        ltc_pkg::LTC_MUX_4:      nxt_st.bp[i] = (st_ff.row == 3'(i % 4)); // [RULE17]
        ltc_pkg::LTC_MUX_6:      nxt_st.bp[i] = (st_ff.row == 3'(i % 6)); // [RULE17]
        default:                 nxt_st.bp[i] = (st_ff.row == 3'(i)); // [RULE17]
      endcase
    end
    // Each segment shows its column's bit for the active row.
    for (int j = 0; j < 60; j++) begin
      nxt_st.seg[j] = st_ff.disp[j][st_ff.row]; // [RULE18]
    end
  end

  // Synchronous reset gives every control field its defined value.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_ff        <= '0;
      st_ff.mode   <= ltc_pkg::LTC_MUX_STATIC;
      st_ff.slopes <= ltc_pkg::SLOPE_RST;
      st_ff.vset   <= ltc_pkg::VOLT_RST; // [RULE5]
      st_ff.temp   <= ltc_pkg::TEMP_RST; // [RULE5]
      st_ff.presc  <= ltc_pkg::PRESC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cif.comp_enable_flag    = st_ff.comp_en;
  assign cif.slope_codes         = st_ff.slopes;
  assign cif.lcd_voltage_setting = st_ff.vset;
  assign cif.temp_code           = st_ff.temp;

  ltc_temp_comp ltc_temp_comp_i (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .cif       (cif)
  );

  // The pin is released at reset and whenever the external clock is chosen.
  assign clk_pin_o       = st_ff.clk_out;
  assign clk_pin_oe_o    = st_ff.clock_pin_drive_enable && !st_ff.ext_sel; // [RULE11] [RULE12]
  assign reg_rdata_o     = st_ff.rdata;
  assign frame_tick_o    = st_ff.frame;
  assign backplane_out_o = st_ff.bp;
  assign segment_out_o   = st_ff.seg;
  assign vlcd_code_o     = cif.final_code;

  // Helper: ticks counted independently since the last frame pulse.
  logic [7:0] chk_ticks_ff;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || frame_tick_o) begin
      chk_ticks_ff <= 8'h00;
    end else if (tick && chk_ticks_ff != 8'hff) begin
      chk_ticks_ff <= chk_ticks_ff + 8'h01;
    end
  end

  frame_len_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE13]
    $rose(frame_tick_o) && $past(st_ff.fcnt, 2) != 6'h00 |-> chk_ticks_ff == 8'h30)
    else $error("frame not 48 ticks long");
  pin_drive_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE11]
    clk_pin_oe_o |-> $past(reg_wr_i && reg_addr_i == ltc_pkg::ADR_CTRL, 1) ||
      ($past(clk_pin_oe_o) && !st_ff.ext_sel))
    else $error("clock pin driven without enable");
  bp_quad_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE17]
    st_ff.mode == ltc_pkg::LTC_MUX_4 [*2] |-> backplane_out_o[7:4] == backplane_out_o[3:0])
    else $error("quad backplane repeat broken");
  bp_static_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE17]
    st_ff.mode == ltc_pkg::LTC_MUX_STATIC [*2] |-> backplane_out_o == 8'hff)
    else $error("static backplanes differ");
  ext_tick_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE12]
    st_ff.ext_sel && tick |-> clk_pin_i && !$past(clk_pin_i))
    else $error("external tick without pin edge");
endmodule // ltc_core

/* File: sim/ltc_glass_model.sv */
// Far-side model: the clock source that an application may hang on the clock pin.
// Assumes the bench resolves the pin level from the core's output enable.
module ltc_glass_model #(
  parameter int unsigned HALF = 3
) (
  input  wire logic ref_clk_i,
  input  wire logic run_i,
  output logic      pin_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt_ff = 0;
  // Once started the clock never pauses, as a stopped clock leaves the glass in DC.
  always @(posedge ref_clk_i) begin
    if (!run_i) begin
      cnt_ff <= 0;
      pin_o  <= ~pin_o;  // A released pin floats, so it is shown as a moving level.
    end else if (cnt_ff == HALF - 1) begin
      cnt_ff <= 0;
      pin_o  <= ~pin_o;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule // ltc_glass_model

/* File: sim/ltc_core_tb.sv */
// Bench for the LCD core: register port, compensation, clock pin and drive outputs.
// Assumes reads answer one cycle after the strobe and compensation settles in two.
module ltc_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 40000;
  localparam int CPER  = 6;  // Reference cycles per external clock period.
  logic        ref_clk_i;
  logic        srst_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic        clk_pin_o;
  logic        clk_pin_oe_o;
  logic        frame_tick_o;
  logic [7:0]  backplane_out_o;
  logic [59:0] segment_out_o;
  logic [7:0]  vlcd_code_o;
  logic        ext_run = 1'b0;
  logic        ext_pin;
  logic [15:0] rv;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          c8[8] = '{0, -1, -2, -4, -10, 1, 2, 4};
  wire logic   pin_lvl = clk_pin_oe_o ? clk_pin_o : ext_pin;

  ltc_core ltc_core_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .clk_pin_i(pin_lvl), .clk_pin_o(clk_pin_o),
    .clk_pin_oe_o(clk_pin_oe_o), .frame_tick_o(frame_tick_o),
    .backplane_out_o(backplane_out_o), .segment_out_o(segment_out_o),
    .vlcd_code_o(vlcd_code_o));
  ltc_glass_model #(.HALF(CPER / 2)) ltc_glass_model_i (.ref_clk_i(ref_clk_i),
    .run_i(ext_run), .pin_o(ext_pin));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang is cut short here rather than left to run forever.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Offset in whole steps from coefficients in eighths, rounded half up.
  function automatic int exp_off(input int t, input int a, input int b, input int c,
                                 input int d);
    int p;
    if (t <= 32) p = (t - 32) * a - 32 * b;
    else if (t <= 64) p = (t - 64) * b;
    else if (t <= 96) p = (t - 64) * c;
    else if (t <= 126) p = (t - 96) * d + 32 * c;
    else p = 31 * d + 32 * c;
    return (p + 4) >>> 3;
  endfunction

  task automatic comp_case(input logic en, input int sa, input int sb, input int sc,
                           input int sd, input int v, input int t);
    int off;
    int fin;
    off = exp_off(t, c8[sa], c8[sb], c8[sc], c8[sd]);
    fin = en ? v + off : v;
    fin = fin < 0 ? 0 : (fin > 255 ? 255 : fin);
    wr(ltc_pkg::ADR_CTRL, 16'(en) << ltc_pkg::CTRL_COMP);
    wr(ltc_pkg::ADR_SLOPE, {4'h0, 3'(sd), 3'(sc), 3'(sb), 3'(sa)});
    wr(ltc_pkg::ADR_VOLT, 16'(v));
    wr(ltc_pkg::ADR_TEMP, 16'(t));
    repeat (3) @(posedge ref_clk_i);
    #1 chk("vlcd_code_o", 16'(fin), {8'h00, vlcd_code_o});
    rd(ltc_pkg::ADR_FINAL, rv);
    chk("final field", 16'(fin), {8'h00, rv[7:0]});
    if (en) chk("offset field", 16'(off & 255), {8'h00, rv[15:8]});
  endtask

  task automatic t_reset();
    #1 chk("vlcd after reset", 16'h0000, {8'h00, vlcd_code_o});
    chk("pin enable at reset", 16'h0000, {15'h0000, clk_pin_oe_o});
    rd(ltc_pkg::ADR_TEMP, rv);
    chk("temp code", 16'h0040, rv);
    rd(ltc_pkg::ADR_SLOPE, rv);
    chk("slope codes", 16'h0000, rv);
    wr(ltc_pkg::ADR_FINAL, 16'hffff);
    wr(4'hf, 16'hffff);
    rd(ltc_pkg::ADR_FINAL, rv);
    chk("final after reset", 16'h0000, rv);
    rd(4'hf, rv);
    chk("unmapped read", 16'h0000, rv);
  endtask

  // Every slope code in region two, then each region, both clamps and the hold.
  task automatic t_comp();
    for (int k = 0; k < 8; k++) begin
      comp_case(1'b1, k, k, k, k, 128, 34);
    end
    comp_case(1'b1, 4, 4, 0, 0, 192, 0);
    comp_case(1'b1, 0, 0, 4, 0, 0, 65);
    comp_case(1'b1, 0, 0, 3, 0, 128, 80);
    comp_case(1'b1, 0, 0, 6, 7, 16, 112);
    comp_case(1'b1, 0, 0, 6, 7, 16, 127);
    comp_case(1'b1, 0, 0, 6, 7, 16, 255);
    comp_case(1'b0, 4, 4, 0, 0, 51, 0);
  endtask

  task automatic t_clkpin();
    int hi;
    int per;
    int lens[3] = '{6944, 1436, 1388};
    logic [4:0] codes[3] = '{5'h00, 5'h17, 5'h1f};
    wr(ltc_pkg::ADR_CTRL, 16'h0001 << ltc_pkg::CTRL_COE);
    repeat (2) @(posedge ref_clk_i);
    #1 chk("pin enable internal", 16'h0001, {15'h0000, clk_pin_oe_o});
    for (int i = 0; i < 3; i++) begin
      wr(ltc_pkg::ADR_PRESC, {11'h000, codes[i]});
      repeat (2) @(posedge clk_pin_o);
      hi = 0;
      #1;
      while (clk_pin_o === 1'b1) begin @(posedge ref_clk_i); #1 hi++; end
      per = hi;
      while (clk_pin_o === 1'b0) begin @(posedge ref_clk_i); #1 per++; end
      chk("pin period", 16'(lens[i]), 16'(per));
      chk("pin high time", 16'(lens[i] / 2), 16'(hi));
    end
  endtask

  task automatic t_drive();
    int n[5] = '{1, 2, 4, 6, 8};
    logic [7:0] seen;
    logic [7:0] prev;
    logic [7:0] ex;
    int r;
    int last;
    wr(ltc_pkg::ADR_DCOL, 16'h0000);
    wr(ltc_pkg::ADR_DDATA, 16'h00a5);
    wr(ltc_pkg::ADR_DCOL, 16'h003b);
    wr(ltc_pkg::ADR_DDATA, 16'h003c);
    rd(ltc_pkg::ADR_DDATA, rv);
    chk("column 59 data", 16'h003c, rv);
    wr(ltc_pkg::ADR_DCOL, 16'h003c);
    wr(ltc_pkg::ADR_DDATA, 16'h00ff);
    rd(ltc_pkg::ADR_DDATA, rv);
    chk("column 60 data", 16'h0000, rv);
    ext_run <= 1'b1;
    for (int m = 0; m < 5; m++) begin
      // External clock with the drive enable also set; 1:8 is asked for by an
      // out-of-range mode field of seven, which must read back as 1:8.
      wr(ltc_pkg::ADR_CTRL, (16'((m == 4) ? 7 : m) << ltc_pkg::CTRL_MODE) |
         (16'h0003 << ltc_pkg::CTRL_EXT));
      rd(ltc_pkg::ADR_CTRL, rv);
      chk("control readback", (16'(m) << ltc_pkg::CTRL_MODE) | 16'h0006, rv);
      repeat (48 * CPER + 8) @(posedge ref_clk_i);
      #1 chk("pin enable external", 16'h0000, {15'h0000, clk_pin_oe_o});
      seen = 8'h00;
      prev = 8'h00;
      last = -1;
      for (int c = 0; c < 2 * 48 * CPER + 8; c++) begin
        @(posedge ref_clk_i);
        #1;
        if (frame_tick_o === 1'b1) begin
          if (last >= 0) chk("frame period", 16'(48 * CPER), 16'(c - last));
          last = c;
        end
        // Only settled rows are judged; the outputs may trail a row change by a cycle.
        if (backplane_out_o === prev) begin
          r = 0;
          while (r < 7 && backplane_out_o[r] !== 1'b1) r++;
          for (int i = 0; i < 8; i++) ex[i] = (i % n[m]) == r;
          chk("backplane", {8'h00, ex}, {8'h00, backplane_out_o});
          chk("segment 0", 16'((8'ha5 >> r) & 8'h01), 16'(segment_out_o[0]));
          chk("segment 59", 16'((8'h3c >> r) & 8'h01), 16'(segment_out_o[59]));
          seen[r] = 1'b1;
        end
        prev = backplane_out_o;
      end
      chk("rows visited", 16'((1 << n[m]) - 1), {8'h00, seen});
    end
    ext_run <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset();
    t_comp();
    t_clkpin();
    t_drive();
    finish_test();
  end
endmodule // ltc_core_tb
